// >>> rtl/sbs_tap.sv
`timescale 1ns/1ps
// Summary of operation
// - sample on rising, drive on falling tck
// - mode and data synchronisers reset high
// - shift in at msb, out at lsb
// - tdo drives only in shift states
// - five high tms edges reach reset
// - power-up reset floats tdo
// - instruction selects exactly one data register
// - three-bit instruction register shifts in shift-IR
// - identify instruction loaded at reset
// - capture-IR loads 01 into low bits
// - bypass bit cleared on capture
// - boundary register captures all pins, then shifts
// - identify instruction captures fixed 32-bit code
// - new instruction active only at update-IR
// - sample-and-float selects boundary, floats read bus
// - sample/preload snapshots pins, sram undisturbed
// - update-DR moves shifted cells into latches
// - external test drives latched values out
// - cell 108 gates read bus under external test
// - cell 108 latch preset high at reset
// - code 001 identify, 111 bypass
// - code 010 float, 100 preload, 000 external test, others reserved
// - transitions decided by tms at rising edge
// - identification bit 0 always one
module sbs_tap
    import sbs_pkg::*;
#(
    parameter int IR_W = SBS_IR_W,
    parameter int ID_W = SBS_ID_W,
    parameter int BSR_W = SBS_BSR_W,
    parameter int OE_BIT = SBS_OE_BIT,
    parameter logic [31:0] ID_CODE = SBS_ID_CODE
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    // test port pins, all asynchronous to clk_sys
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // pin ring seen by the boundary register
    input wire logic [BSR_W-1:0] ring_in,
    output logic [BSR_W-1:0] ring_out,
    output logic extest_on,
    output logic q_bus_oe,
    // avalon-mm register slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ***************************************************************
    // derived constants
    // ***************************************************************
    // latch pattern after reset: only the output-enable cell is set, so
    // the read bus stays with the sram until a test takes it over
    localparam logic [BSR_W-1:0] LAT_RESET =
        {{(BSR_W-1){1'b0}}, 1'b1} << OE_BIT;
    // width of the one-hot state field in the status word
    localparam int ST_W = $bits(sbs_state_e);

    // ***************************************************************
    // state record
    // ***************************************************************
    // synchronisers first, then the scan stages and the bus state
    typedef struct packed {
        logic tck_s1; // synchroniser stage one, read only by stage two
        logic tck_s2; // synchronised test clock
        logic tck_d; // previous test clock, for edge finding
        logic tms_s1;
        logic tms_s2;
        logic tdi_s1;
        logic tdi_s2;
        logic [BSR_W-1:0] ring_s1; // pin ring synchroniser
        logic [BSR_W-1:0] ring_s2;
        sbs_state_e st; // tap controller state
        logic [IR_W-1:0] ir_sh; // instruction shift stage
        logic [IR_W-1:0] ir; // current instruction
        logic byp; // bypass bit
        logic [ID_W-1:0] id_sh; // identification shift stage
        logic [BSR_W-1:0] bsr_sh; // boundary shift stage
        logic [BSR_W-1:0] bsr_lat; // boundary parallel latches
        logic tdo; // serial output bit
        logic tdo_oe; // serial output driver enable
        logic ext; // external test instruction active
        logic q_oe; // read-data bus enable
        logic [31:0] ctrl; // software control word
        logic [31:0] rdata; // bus read data
        logic wait_r; // bus waitrequest
    } sbs_regs_s;

    sbs_regs_s cur; // registered state
    sbs_regs_s next_cur; // next state

    // ***************************************************************
    // helper functions
    // ***************************************************************
    // next controller state from tms sampled at a rising tck edge
    // a held-high tms walks any state to reset within five edges
    function automatic sbs_state_e sbs_step(input sbs_state_e s,
                                            input logic m);
        sbs_state_e n;
        n = SBS_TLR;
        case (s)
            SBS_TLR: n = m ? SBS_TLR : SBS_RTI;
            SBS_RTI: n = m ? SBS_SEL_DR : SBS_RTI;
            SBS_SEL_DR: n = m ? SBS_SEL_IR : SBS_CAP_DR;
            SBS_CAP_DR: n = m ? SBS_EX1_DR : SBS_SHF_DR;
            SBS_SHF_DR: n = m ? SBS_EX1_DR : SBS_SHF_DR;
            SBS_EX1_DR: n = m ? SBS_UPD_DR : SBS_PAU_DR;
            SBS_PAU_DR: n = m ? SBS_EX2_DR : SBS_PAU_DR;
            SBS_EX2_DR: n = m ? SBS_UPD_DR : SBS_SHF_DR;
            SBS_UPD_DR: n = m ? SBS_SEL_DR : SBS_RTI;
            SBS_SEL_IR: n = m ? SBS_TLR : SBS_CAP_IR;
            SBS_CAP_IR: n = m ? SBS_EX1_IR : SBS_SHF_IR;
            SBS_SHF_IR: n = m ? SBS_EX1_IR : SBS_SHF_IR;
            SBS_EX1_IR: n = m ? SBS_UPD_IR : SBS_PAU_IR;
            SBS_PAU_IR: n = m ? SBS_EX2_IR : SBS_PAU_IR;
            SBS_EX2_IR: n = m ? SBS_UPD_IR : SBS_SHF_IR;
            SBS_UPD_IR: n = m ? SBS_SEL_DR : SBS_RTI;
            default: n = SBS_TLR;
        endcase
        return n;
    endfunction

    // instruction decode to the one selected data register
    // reserved codes fall to bypass so a stray load keeps the chain
    // length known instead of leaving the serial path open
    function automatic sbs_sel_e sbs_pick(input logic [IR_W-1:0] i);
        sbs_sel_e p;
        p = SBS_SEL_BYP;
        if (i == SBS_INS_IDCODE) begin
            p = SBS_SEL_ID;
        end else if (i == SBS_INS_EXTEST || i == SBS_INS_SAMPLE_Z ||
                     i == SBS_INS_SAMPLE) begin
            p = SBS_SEL_BSR;
        end else begin
            // bypass, and reserved codes fall back to the short path
            p = SBS_SEL_BYP;
        end
        return p;
    endfunction

    // read-data bus enable for a given instruction and latch state
    // only external test hands the bus enable to the latched cell
    function automatic logic sbs_qoe(input logic [IR_W-1:0] i,
                                     input logic oe_cell);
        logic r;
        r = 1'b1;
        if (i == SBS_INS_SAMPLE_Z) begin
            r = 1'b0;
        end else if (i == SBS_INS_EXTEST) begin
            r = oe_cell;
        end
        return r;
    endfunction

    // ***************************************************************
    // next-state logic
    // ***************************************************************
    // edges of the sampled test clock, one clk_sys cycle each; tck must
    // stay high and low for three clk_sys periods at least, or an edge
    // is lost in the synchroniser and the controller falls out of step
    logic tck_rise;
    logic tck_fall;
    sbs_sel_e sel;
    logic bus_go;

    always_comb begin
        next_cur = cur;
        tck_rise = cur.tck_s2 & ~cur.tck_d;
        tck_fall = ~cur.tck_s2 & cur.tck_d;
        sel = sbs_pick(cur.ir);
        bus_go = ~cur.wait_r;

        // two-flop synchronisers; only stage two is looked at
        // stage one may go metastable, so nothing but stage two reads it
        next_cur.tck_s1 = tck;
        next_cur.tck_s2 = cur.tck_s1;
        next_cur.tck_d = cur.tck_s2;
        next_cur.tms_s1 = tms;
        next_cur.tms_s2 = cur.tms_s1;
        next_cur.tdi_s1 = tdi;
        next_cur.tdi_s2 = cur.tdi_s1;
        next_cur.ring_s1 = ring_in;
        next_cur.ring_s2 = cur.ring_s1;

        // rising tck: sample tms and tdi, capture and shift
        if (tck_rise) begin
            next_cur.st = sbs_step(cur.st, cur.tms_s2);
            case (cur.st)
                SBS_CAP_IR: begin
                    next_cur.ir_sh = {{(IR_W-2){1'b0}},
                                      SBS_IR_CAPTURE};
                end
                SBS_SHF_IR: begin
                    next_cur.ir_sh = {cur.tdi_s2,
                                      cur.ir_sh[IR_W-1:1]};
                end
                SBS_CAP_DR: begin
                    case (sel)
                        SBS_SEL_ID: begin
                            next_cur.id_sh = ID_CODE[ID_W-1:0] |
                                {{(ID_W-1){1'b0}}, 1'b1};
                        end
                        SBS_SEL_BSR: begin
                            // snapshot only; sram paths are untouched
                            next_cur.bsr_sh = cur.ring_s2;
                        end
                        default: begin
                            // bypass, and any reserved code
                            next_cur.byp = 1'b0;
                        end
                    endcase
                end
                SBS_SHF_DR: begin
                    case (sel)
                        SBS_SEL_ID: begin
                            next_cur.id_sh = {cur.tdi_s2,
                                              cur.id_sh[ID_W-1:1]};
                        end
                        SBS_SEL_BSR: begin
                            // captured bits leave while preload enters
                            next_cur.bsr_sh = {cur.tdi_s2,
                                cur.bsr_sh[BSR_W-1:1]};
                        end
                        default: begin
                            // one-bit path: each bit lags by one edge
                            next_cur.byp = cur.tdi_s2;
                        end
                    endcase
                end
                default: begin
                    // other states hold every scan stage
                end
            endcase
        end

        // falling tck: drive tdo and perform updates
        if (tck_fall) begin
            case (cur.st)
                SBS_SHF_IR: begin
                    next_cur.tdo = cur.ir_sh[0];
                    next_cur.tdo_oe = 1'b1;
                end
                SBS_SHF_DR: begin
                    case (sel)
                        SBS_SEL_ID: next_cur.tdo = cur.id_sh[0];
                        SBS_SEL_BSR: next_cur.tdo = cur.bsr_sh[0];
                        default: next_cur.tdo = cur.byp;
                    endcase
                    next_cur.tdo_oe = 1'b1;
                end
                default: begin
                    // leaving a shift state releases the pin
                    next_cur.tdo_oe = 1'b0;
                end
            endcase
            // updates sit on the falling edge so the new instruction and
            // latches never change under a rising-edge capture
            if (cur.st == SBS_UPD_IR) begin
                next_cur.ir = cur.ir_sh;
            end
            if (cur.st == SBS_UPD_DR && sel == SBS_SEL_BSR) begin
                next_cur.bsr_lat = cur.bsr_sh;
            end
            // reset state restores the power-up instruction and cell
            if (cur.st == SBS_TLR) begin
                next_cur.ir = SBS_INS_IDCODE;
                next_cur.bsr_lat[OE_BIT] = 1'b1;
            end
        end

        // software may hold the port in test-logic-reset
        // this wins over any tck edge seen in the same cycle
        if (cur.ctrl[SBS_CTRL_RST_BIT]) begin
            next_cur.st = SBS_TLR;
            next_cur.ir = SBS_INS_IDCODE;
            next_cur.bsr_lat[OE_BIT] = 1'b1;
            next_cur.tdo_oe = 1'b0;
        end

        // pin-facing controls follow the active instruction
        // taken from the next values so they land with the instruction
        next_cur.ext = (next_cur.ir == SBS_INS_EXTEST);
        next_cur.q_oe = sbs_qoe(next_cur.ir,
                                next_cur.bsr_lat[OE_BIT]);

        // avalon slave: waitrequest drops one cycle after a request
        // every access costs two cycles; the registered answer keeps
        // readdata and waitrequest clean at the price of speed
        next_cur.wait_r = 1'b1;
        if ((avs_read | avs_write) & cur.wait_r) begin
            next_cur.wait_r = 1'b0;
            next_cur.rdata = 32'h0000_0000;
            if (avs_address == SBS_REG_STATUS) begin
                next_cur.rdata[SBS_ST_STATE_LSB +: ST_W] = cur.st;
                next_cur.rdata[SBS_ST_INS_LSB +: IR_W] = cur.ir;
                next_cur.rdata[SBS_ST_QOE_BIT] = cur.q_oe;
                next_cur.rdata[SBS_ST_LOE_BIT] = cur.bsr_lat[OE_BIT];
            end else if (avs_address == SBS_REG_CTRL) begin
                next_cur.rdata = cur.ctrl;
            end else begin
                // unmapped: reads zero, writes ignored
                next_cur.rdata = 32'h0000_0000;
            end
        end
        // a write takes effect at the edge where waitrequest is low
        // the status word is read only; writes to it are dropped
        if (bus_go & avs_write & (avs_address == SBS_REG_CTRL)) begin
            next_cur.ctrl = avs_writedata;
        end
    end

    // ***************************************************************
    // state register
    // ***************************************************************
    // power-up reset: tdo floats, identify loaded, cell 108 high;
    // tms and tdi synchronisers start high, so both read one until the pins pass through
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cur.tck_s1 <= 1'b0;
            cur.tck_s2 <= 1'b0;
            cur.tck_d <= 1'b0;
            cur.tms_s1 <= 1'b1;
            cur.tms_s2 <= 1'b1;
            cur.tdi_s1 <= 1'b1;
            cur.tdi_s2 <= 1'b1;
            cur.ring_s1 <= '0;
            cur.ring_s2 <= '0;
            cur.st <= SBS_TLR;
            cur.ir_sh <= '0;
            cur.ir <= SBS_INS_IDCODE;
            cur.byp <= 1'b0;
            cur.id_sh <= '0;
            cur.bsr_sh <= '0;
            cur.bsr_lat <= LAT_RESET;
            cur.tdo <= 1'b0;
            cur.tdo_oe <= 1'b0;
            cur.ext <= 1'b0;
            cur.q_oe <= 1'b1;
            cur.ctrl <= SBS_CTRL_RESET;
            cur.rdata <= 32'h0000_0000;
            cur.wait_r <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // ***************************************************************
    // outputs, each straight from the state record
    // ***************************************************************
    // ring_out only matters while extest_on is high; the pad mux
    // outside picks between it and the normal sram path
    // with tdo_oe low the far side must treat tdo as undefined
    assign tdo = cur.tdo;
    assign tdo_oe = cur.tdo_oe;
    assign ring_out = cur.bsr_lat;
    assign extest_on = cur.ext;
    assign q_bus_oe = cur.q_oe;
    assign avs_readdata = cur.rdata;
    assign avs_waitrequest = cur.wait_r;

endmodule

// >>> shared/sbs_pkg.sv
// ***********************************************************************
// boundary-scan test port: shared constants and types
// ***********************************************************************
package sbs_pkg;

    // ***************************************************************
    // scan register geometry
    // ***************************************************************
    localparam int SBS_IR_W = 3; // instruction register width
    localparam int SBS_ID_W = 32; // identification register width
    localparam int SBS_BSR_W = 109; // boundary scan register width
    localparam int SBS_OE_BIT = 108; // output-enable boundary cell
    // arbitrary neutral identity value; bit 0 is forced to one anyway
    localparam logic [31:0] SBS_ID_CODE = 32'h5ABC_D001;
    localparam logic [1:0] SBS_IR_CAPTURE = 2'h1; // capture-IR pattern

    // ***************************************************************
    // instruction codes
    // ***************************************************************
    localparam logic [2:0] SBS_INS_EXTEST = 3'h0;
    localparam logic [2:0] SBS_INS_IDCODE = 3'h1;
    localparam logic [2:0] SBS_INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] SBS_INS_SAMPLE = 3'h4;
    localparam logic [2:0] SBS_INS_BYPASS = 3'h7;

    // ***************************************************************
    // register map (byte addresses) and field positions
    // ***************************************************************
    localparam logic [3:0] SBS_REG_STATUS = 4'h0; // read only
    localparam logic [3:0] SBS_REG_CTRL = 4'h4; // read and write
    localparam int SBS_ST_STATE_LSB = 0; // tap state, 16 bits
    localparam int SBS_ST_INS_LSB = 16; // current instruction
    localparam int SBS_ST_QOE_BIT = 19; // read-data bus enable
    localparam int SBS_ST_LOE_BIT = 20; // latched output-enable cell
    localparam int SBS_CTRL_RST_BIT = 0; // hold tap in reset
    localparam logic [31:0] SBS_CTRL_RESET = 32'h0000_0000;

    // ***************************************************************
    // tap controller states, one-hot
    // ***************************************************************
    typedef enum logic [15:0] {
        SBS_TLR = 16'h0001,
        SBS_RTI = 16'h0002,
        SBS_SEL_DR = 16'h0004,
        SBS_CAP_DR = 16'h0008,
        SBS_SHF_DR = 16'h0010,
        SBS_EX1_DR = 16'h0020,
        SBS_PAU_DR = 16'h0040,
        SBS_EX2_DR = 16'h0080,
        SBS_UPD_DR = 16'h0100,
        SBS_SEL_IR = 16'h0200,
        SBS_CAP_IR = 16'h0400,
        SBS_SHF_IR = 16'h0800,
        SBS_EX1_IR = 16'h1000,
        SBS_PAU_IR = 16'h2000,
        SBS_EX2_IR = 16'h4000,
        SBS_UPD_IR = 16'h8000
    } sbs_state_e;

    // data register selected by the current instruction
    typedef enum logic [2:0] {
        SBS_SEL_BYP = 3'h1,
        SBS_SEL_ID = 3'h2,
        SBS_SEL_BSR = 3'h4
    } sbs_sel_e;

endpackage

// >>> tb/sbs_tap_checker.sv
`timescale 1ns/1ps
// ********************************************
// checker on the tap pins and bus ports
// ********************************************
module sbs_tap_checker
    import sbs_pkg::*;
#(
    parameter int BSR_W = SBS_BSR_W,
    parameter int OE_BIT = SBS_OE_BIT
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [BSR_W-1:0] ring_out,
    input wire logic extest_on,
    input wire logic q_bus_oe,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // a request taken, then the one-cycle answer
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_bus_answer: assert property (s_req |=> s_ans)
        else $error("bus answer not one cycle after request");
    a_bus_cause: assert property (!avs_waitrequest |->
        $past(avs_read || avs_write))
        else $error("bus answer without request");
    a_data_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
        else $error("read data moved between answers");
    // mode and cell settled first; the latch and the enable land in the same cycle
    a_oe_latch: assert property (extest_on && $stable(ring_out) &&
        $stable(extest_on) |-> q_bus_oe == ring_out[OE_BIT])
        else $error("read bus enable differs from latched cell");
    a_tdo_hold: assert property ($rose(tck) |=> $stable(tdo)[*3])
        else $error("tdo moved while tck high");
    a_tdo_quiet: assert property ((!tck)[*8] |->
        $stable(tdo) && $stable(tdo_oe))
        else $error("tdo moved with tck idle");
    a_rst_float: assert property ($fell(sys_rst) |->
        !tdo_oe && !extest_on)
        else $error("tdo driven after reset");
    a_rst_latch: assert property ($fell(sys_rst) |->
        ring_out[OE_BIT] && q_bus_oe)
        else $error("enable cell not preset high after reset");
endmodule
bind sbs_tap sbs_tap_checker #(.BSR_W(BSR_W), .OE_BIT(OE_BIT)) u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .tck(tck), .tdo(tdo),
    .tdo_oe(tdo_oe), .ring_out(ring_out), .extest_on(extest_on),
    .q_bus_oe(q_bus_oe), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// >>> tb/sbs_jtag_ctl.sv
`timescale 1ns/1ps
// ********************************************
// external scan controller driving the test port
// ********************************************
module sbs_jtag_ctl (
    input wire logic clk_sys,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // tck idles low between frames, data idles high, mode starts high
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
    end
    // one tck period of 8 clk: 5 low, 3 high, i.e. 320 ns
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (5) @(posedge clk_sys);
        // a released tdo is read inverted, never as the last bit
        q = tdo_oe ? tdo : ~tdo;
        tck <= 1'h1;
        repeat (3) @(posedge clk_sys);
        tck <= 1'h0;
    endtask
    // five rising edges with mode high
    task automatic hold5;
        logic q;
        repeat (5) step(1'h1, 1'h1, q);
    endtask
    // full ir or dr scan from idle, back to idle through update
    task automatic scan(input logic ir, input int n,
        input logic [127:0] din, output logic [127:0] dout);
        logic q;
        dout = '0;
        step(1'h0, 1'h1, q);
        step(1'h1, 1'h1, q);
        if (ir) begin
            step(1'h1, 1'h1, q);
        end
        step(1'h0, 1'h1, q);
        step(1'h0, 1'h1, q);
        for (int i = 0; i < n; i++) begin
            step(logic'(i == n - 1), din[i], q);
            dout[i] = q;
        end
        step(1'h1, 1'h1, q);
        step(1'h0, 1'h1, q);
    endtask
endmodule

// >>> tb/tb_sbs_tap.sv
`timescale 1ns/1ps
// ********************************************
// testbench for the boundary-scan test port
// ********************************************
module tb_sbs_tap;
    import sbs_pkg::*;
    int failures = 0;
    int samples_checked = 0;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    logic tck, tms, tdi, tdo, tdo_oe, extest_on, q_bus_oe;
    logic [108:0] ring_in = {1'h0, {4{27'h2A5_C3F1}}};
    logic [108:0] ring_out;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    always #20 clk_sys = ~clk_sys;
    sbs_tap dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .ring_in(ring_in), .ring_out(ring_out), .extest_on(extest_on),
        .q_bus_oe(q_bus_oe), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    sbs_jtag_ctl u_ctl (.clk_sys(clk_sys), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    // ********************************************
    // shared tasks
    // ********************************************
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp,
        input string what);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 20);
        if (avs_waitrequest !== 1'h0) begin
            failures++;
            stop_test;
        end
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    function automatic logic [31:0] st(input logic [15:0] s,
        input logic [2:0] i, input logic qo, input logic lo);
        return {11'h0, lo, qo, i, s};
    endfunction
    // ********************************************
    // main sequence
    // ********************************************
    initial begin
        logic [31:0] q;
        logic [127:0] din, dout;
        logic [2:0] c;
        logic [31:0] rst_st;
        logic qo, b;
        // implemented codes only; reserved ones are never loaded
        logic [2:0] codes [4] = '{3'h7, 3'h2, 3'h4, 3'h0};
        rst_st = st(SBS_TLR, SBS_INS_IDCODE, 1'h1, 1'h1);
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'h0;
        repeat (4) @(posedge clk_sys);
        chk(tdo_oe, 1'h0, "tdo_oe at power-up");
        bus(1'h0, SBS_REG_STATUS, 32'h0, q);
        chk(q, rst_st, "status");
        bus(1'h0, 4'h8, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        bus(1'h1, SBS_REG_CTRL, 32'h1, q);
        bus(1'h0, SBS_REG_CTRL, 32'h0, q);
        chk(q, 32'h1, "ctrl readback");
        bus(1'h1, SBS_REG_CTRL, 32'h0, q);
        // id capture, then tdi bits must reach tdo after 32 shifts
        u_ctl.scan(1'h0, 64, {96'h0, 32'hA5C3_0F96}, dout);
        chk(dout[31:0], SBS_ID_CODE, "id code");
        chk(dout[0], 1'h1, "id bit 0");
        chk(dout[63:32], 32'hA5C3_0F96, "id shift-through");
        foreach (codes[k]) begin
            c = codes[k];
            din = {19'h0, 1'h1, {4{27'h13C_96A5}}} ^ {125'h0, c};
            if (c == SBS_INS_EXTEST) begin
                din[108] = 1'h0;
            end
            u_ctl.scan(1'h1, 3, {125'h0, c}, dout);
            chk(dout[1:0], SBS_IR_CAPTURE, "ir capture");
            bus(1'h0, SBS_REG_STATUS, 32'h0, q);
            chk(q[18:0], {c, SBS_RTI}, "current code");
            if (c == SBS_INS_BYPASS) begin
                // the single bypass bit is zero after capture
                u_ctl.scan(1'h0, 8, {120'h0, 8'hB4}, dout);
                chk(dout[7:0], 8'h68, "bypass path");
            end else begin
                u_ctl.scan(1'h0, 109, din, dout);
                repeat (6) @(posedge clk_sys);
                chk(dout[108:0], ring_in, "ring capture");
                chk(ring_out, din[108:0], "preload latch");
                chk(extest_on, logic'(c == 3'h0), "extest");
                qo = (c == SBS_INS_SAMPLE_Z) ? 1'h0 :
                    ((c == SBS_INS_EXTEST) ? din[108] : 1'h1);
                chk(q_bus_oe, qo, "q bus");
            end
        end
        repeat (10) @(posedge clk_sys);
        chk(tdo_oe, 1'h0, "tdo_oe idle");
        // from shift-DR, five high tms edges must still reach reset
        u_ctl.step(1'h1, 1'h1, b);
        u_ctl.step(1'h0, 1'h1, b);
        u_ctl.step(1'h0, 1'h1, b);
        u_ctl.hold5;
        repeat (6) @(posedge clk_sys);
        bus(1'h0, SBS_REG_STATUS, 32'h0, q);
        chk(q, rst_st, "tap reset");
        // software hold forces reset out of a loaded external test
        u_ctl.scan(1'h1, 3, 128'h0, dout);
        bus(1'h1, SBS_REG_CTRL, 32'h1, q);
        bus(1'h0, SBS_REG_STATUS, 32'h0, q);
        chk(q, rst_st, "ctrl hold");
        bus(1'h1, SBS_REG_CTRL, 32'h0, q);
        stop_test;
    end
endmodule
